// ### rtl/ihc_pkg.sv
/*
  Constants and types of the interrupt and halt controller.
  Assumes a 32-bit APB slave where each register index is one word.
*/
package ihc_pkg;
  // Bus geometry
  localparam int IHC_ADDR_W = 10;
  localparam int IHC_DATA_W = 32;
  // Register indices, byte address is four times the index
  localparam logic [7:0] IDX_KEY_EN = 8'hE8;
  localparam logic [7:0] IDX_TICK_EN = 8'hEB;
  localparam logic [7:0] IDX_KEY_PEND = 8'hED;
  localparam logic [7:0] IDX_TICK_PEND = 8'hEF;
  localparam logic [7:0] IDX_CTRL = 8'hF0;
  localparam logic [7:0] IDX_EVT_STAT = 8'hF1;
  localparam logic [7:0] IDX_EVT_MASK = 8'hF2;
  // Field positions
  localparam int TICK_FAST_BIT = 0;
  localparam int TICK_MID_BIT = 1;
  localparam int TICK_SLOW_BIT = 2;
  localparam int KEY_PEND_BIT = 0;
  localparam int CTRL_GIE_BIT = 0;
  localparam int EVT_ENTRY_BIT = 0;
  localparam int EVT_WAKE_BIT = 1;
  // Widths
  localparam int TICK_N = 3;
  localparam int KEY_N = 4;
  localparam int EVT_N = 2;
  localparam int PC_W = 12;
  // Reset values
  localparam logic [KEY_N-1:0] RST_KEY_EN = 4'h0;
  localparam logic [TICK_N-1:0] RST_TICK_EN = 3'h0;
  localparam logic [TICK_N-1:0] RST_TICK_PEND = 3'h0;
  localparam logic RST_KEY_PEND = 1'h0;
  localparam logic RST_GIE = 1'h0;
  localparam logic [EVT_N-1:0] RST_EVT = 2'h0;
  // Entry sequence
  localparam int ENTRY_CYCLES = 12;
  localparam logic [3:0] CNT_LOAD = 4'hA;
  localparam logic [3:0] VEC_PAGE = 4'h1;
  localparam logic [7:0] VEC_KEY = 8'h01;
  localparam logic [7:0] VEC_TICK = 8'h02;
  typedef enum logic [1:0] {
    IHC_IDLE = 2'b00,
    IHC_PUSH = 2'b01,
    IHC_WAIT = 2'b11,
    IHC_LOAD = 2'b10
  } ihc_entry_t;
endpackage : ihc_pkg

// ### rtl/ihc_interrupt_halt_controller.sv
/*
  Interrupt factor flags, masks, global enable, halt control and
  vectored entry sequencing, with an APB register port.
  Assumes all inputs synchronous to pclk and a core that signals
  instruction boundaries with a one-cycle acknowledge.
*/
`timescale 1ns/1ps
// Notes on behaviour
// - Request needs flag, mask and global enable
// - Accepting an interrupt clears global enable
// - Halt stops core clock; request wakes
// - Tap falling edges set timer flags
// - Any key rising edge sets key flag
// - Flags read-only; read returns then clears
// - Reset clears all factor flags
// - Masks readable, writable; one enables
// - Reset clears all mask bits
// - Timer mask bits align with flags
// - Four key masks qualify one flag
// - Entry first pushes return address
// - Then vector in page one loaded
// - Push and load take twelve cycles
// - Timer flags set even when masked
module ihc_interrupt_halt_controller
  import ihc_pkg::*;
#(
  parameter int PADDR_W = ihc_pkg::IHC_ADDR_W
)
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PADDR_W-1:0] paddr,
  input wire logic [ihc_pkg::IHC_DATA_W-1:0] pwdata,
  output logic pready,
  output logic [ihc_pkg::IHC_DATA_W-1:0] prdata,
  output logic pslverr,
  // Factor sources
  input wire logic [ihc_pkg::TICK_N-1:0] tick_taps,
  input wire logic [ihc_pkg::KEY_N-1:0] key_input_lines,
  // Core sequencer
  input wire logic global_irq_on,
  input wire logic global_irq_off,
  input wire logic halt_exec,
  input wire logic cpu_irq_ack,
  input wire logic [ihc_pkg::PC_W-1:0] pc_next,
  output logic cpu_irq_req,
  output logic cpu_halted,
  output logic cpu_clk_en,
  output logic stack_wr,
  output logic [ihc_pkg::PC_W-1:0] stack_wdata,
  output logic pc_load,
  output logic [ihc_pkg::PC_W-1:0] pc_vector,
  // Event interrupt
  output logic evt_irq
);
  import ihc_pkg::*;
  default clocking cb_main @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  if (PADDR_W < IHC_ADDR_W)
  begin : g_chk
    $error("PADDR_W too small for the register map");
  end

  logic primed;
  logic [TICK_N-1:0] tap_prev;
  logic [KEY_N-1:0] key_prev;
  logic [TICK_N-1:0] tick_fell;
  logic key_rise;
  logic [TICK_N-1:0] tick_pend;
  logic key_pend;
  logic [TICK_N-1:0] tick_en;
  logic [KEY_N-1:0] key_en;
  logic gie;
  logic [EVT_N-1:0] evt_stat;
  logic [EVT_N-1:0] evt_mask;
  logic [EVT_N-1:0] evt_set;
  logic [7:0] idx;
  logic hit;
  logic done;
  logic wr_done;
  logic rd_done;
  logic [IHC_DATA_W-1:0] next_rdata;
  logic [TICK_N-1:0] tick_clr;
  logic key_clr;
  logic tick_req;
  logic key_req;
  logic irq_req_now;
  logic accept;
  logic wake;
  ihc_entry_t state;
  logic [3:0] cnt;

  // Address decode
  assign idx = paddr[9:2];
  assign done = psel && penable && pready;
  assign wr_done = done && pwrite && !pslverr;
  assign rd_done = done && !pwrite;

  always_comb
  begin
    hit = ((paddr >> 10) == '0);
    next_rdata = '0;
    case (idx)
      IDX_KEY_EN: next_rdata[KEY_N-1:0] = key_en;
      IDX_TICK_EN: next_rdata[TICK_N-1:0] = tick_en;
      IDX_KEY_PEND: next_rdata[KEY_PEND_BIT] = key_pend;
      IDX_TICK_PEND: next_rdata[TICK_N-1:0] = tick_pend;
      IDX_CTRL: next_rdata[CTRL_GIE_BIT] = gie;
      IDX_EVT_STAT: next_rdata[EVT_N-1:0] = evt_stat;
      IDX_EVT_MASK: next_rdata[EVT_N-1:0] = evt_mask;
      default: hit = 1'b0;
    endcase
  end

  // APB answer, zero wait states
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end
    else if (psel && !penable)
    begin
      pready <= 1'b1;
      prdata <= pwrite ? '0 : next_rdata;
      pslverr <= !hit;
    end
    else if (done)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Edge detection
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      primed <= 1'b0;
      tap_prev <= '0;
      key_prev <= '0;
    end
    else
    begin
      primed <= 1'b1;
      tap_prev <= tick_taps;
      key_prev <= key_input_lines;
    end
  end

  assign tick_fell = primed ? (tap_prev & ~tick_taps) : '0;
  assign key_rise = primed && ((~key_prev & key_input_lines) != '0);

  assign tick_clr = (rd_done && idx == IDX_TICK_PEND) ? prdata[TICK_N-1:0] : '0;
  assign key_clr = rd_done && idx == IDX_KEY_PEND && prdata[KEY_PEND_BIT];

  for (genvar i = 0; i < TICK_N; i++)
  begin : g_tick
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        tick_pend[i] <= RST_TICK_PEND[i];
      else
        tick_pend[i] <= (tick_pend[i] && !tick_clr[i]) || tick_fell[i];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      key_pend <= RST_KEY_PEND;
    else
      key_pend <= (key_pend && !key_clr) || key_rise;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tick_en <= RST_TICK_EN;
      key_en <= RST_KEY_EN;
    end
    else if (wr_done && idx == IDX_TICK_EN)
      tick_en <= pwdata[TICK_N-1:0];
    else if (wr_done && idx == IDX_KEY_EN)
      key_en <= pwdata[KEY_N-1:0];
  end

  assign tick_req = (tick_pend & tick_en) != '0;
  assign key_req = key_pend && (key_en != '0);
  assign irq_req_now = gie && (tick_req || key_req);
  assign accept = cpu_irq_ack && cpu_irq_req && irq_req_now && (state == IHC_IDLE);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      gie <= RST_GIE;
    else if (accept || global_irq_off)
      gie <= 1'b0;
    else if (global_irq_on)
      gie <= 1'b1;
    else if (wr_done && idx == IDX_CTRL)
      gie <= pwdata[CTRL_GIE_BIT];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cpu_irq_req <= 1'b0;
    else
      cpu_irq_req <= irq_req_now && !accept;
  end

  assign wake = cpu_halted && irq_req_now;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cpu_halted <= 1'b0;
      cpu_clk_en <= 1'b1;
    end
    else if (wake)
    begin
      cpu_halted <= 1'b0;
      cpu_clk_en <= 1'b1;
    end
    else if (halt_exec && !cpu_halted && !irq_req_now)
    begin
      cpu_halted <= 1'b1;
      cpu_clk_en <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= IHC_IDLE;
      cnt <= '0;
    end
    else
    begin
      case (state)
        IHC_IDLE:
          if (accept)
          begin
            state <= IHC_PUSH;
            cnt <= '0;
          end
        IHC_PUSH:
        begin
          state <= IHC_WAIT;
          cnt <= cnt + 4'h1;
        end
        IHC_WAIT:
        begin
          cnt <= cnt + 4'h1;
          if (cnt == CNT_LOAD)
            state <= IHC_LOAD;
        end
        IHC_LOAD: state <= IHC_IDLE;
        default: state <= IHC_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stack_wr <= 1'b0;
      stack_wdata <= '0;
    end
    else
    begin
      stack_wr <= accept;
      if (accept)
        stack_wdata <= pc_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pc_load <= 1'b0;
      pc_vector <= '0;
    end
    else
    begin
      pc_load <= (state == IHC_WAIT) && (cnt == CNT_LOAD);
      if (accept)
        pc_vector <= {VEC_PAGE, key_req ? VEC_KEY : VEC_TICK};
    end
  end

  // Event status, mask and output
  assign evt_set = {wake, accept};
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      evt_stat <= RST_EVT;
      evt_mask <= RST_EVT;
      evt_irq <= 1'b0;
    end
    else
    begin
      if (wr_done && idx == IDX_EVT_STAT)
        evt_stat <= (evt_stat & ~pwdata[EVT_N-1:0]) | evt_set;
      else
        evt_stat <= evt_stat | evt_set;
      if (wr_done && idx == IDX_EVT_MASK)
        evt_mask <= pwdata[EVT_N-1:0];
      evt_irq <= (evt_stat & evt_mask) != '0;
    end
  end

  property p_req_gate;
    cpu_irq_req |-> $past(gie) && $past(tick_req || key_req);
  endproperty
  a_req_gate: assert property (p_req_gate) else $error("request without cause");
  property p_gie_clear;
    accept |=> !gie ##1 !cpu_irq_req;
  endproperty
  a_gie_clear: assert property (p_gie_clear) else $error("enable kept on entry");
  property p_halt;
    halt_exec && !cpu_halted && !irq_req_now |=> cpu_halted && !cpu_clk_en;
  endproperty
  a_halt: assert property (p_halt) else $error("halt not entered");
  property p_wake;
    cpu_halted && irq_req_now |=> !cpu_halted && cpu_clk_en;
  endproperty
  a_wake: assert property (p_wake) else $error("halt not left");
  property p_tick_set;
    primed && $fell(tick_taps[TICK_SLOW_BIT]) |-> ##1 tick_pend[TICK_SLOW_BIT];
  endproperty
  a_tick_set: assert property (p_tick_set) else $error("slow tick flag missed");
  property p_key_set;
    key_rise |=> key_pend;
  endproperty
  a_key_set: assert property (p_key_set) else $error("key flag missed");
  property p_read_clear;
    rd_done && idx == IDX_KEY_PEND && prdata[KEY_PEND_BIT] && !key_rise |=> !key_pend;
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("flag not cleared");
  property p_reset_vals;
    $rose(primed) |-> tick_pend == '0 && !key_pend && tick_en == '0 && key_en == '0;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("bad reset value");
  property p_mask_wr;
    wr_done && idx == IDX_TICK_EN |=> tick_en == $past(pwdata[TICK_N-1:0]);
  endproperty
  a_mask_wr: assert property (p_mask_wr) else $error("mask write lost");
  property p_key_mask;
    key_en == '0 && !tick_req |=> !cpu_irq_req;
  endproperty
  a_key_mask: assert property (p_key_mask) else $error("masked key requested");
  // push then load twelve cycles on
  property p_entry;
    accept |=> stack_wr ##1 (!stack_wr && !pc_load) [*8] ##1 (!stack_wr && !pc_load) [*2]
      ##1 pc_load ##1 !pc_load;
  endproperty
  a_entry: assert property (p_entry) else $error("entry timing wrong");
  property p_vector;
    pc_load |-> pc_vector[11:8] == VEC_PAGE && pc_vector[7:0] inside {[8'h01:8'h07]};
  endproperty
  a_vector: assert property (p_vector) else $error("vector out of page");

  c_entry: cover property (pc_load);
  c_wake: cover property (wake);
  c_key_read: cover property (key_clr);
  c_tick_read: cover property (tick_clr != '0);
endmodule : ihc_interrupt_halt_controller

// ### verif/ihc_core_model.sv
/*
  Core sequencer model for the interrupt and halt controller bench.
  Assumes request and clock enable from the controller on pclk.
*/
`timescale 1ns/1ps
module ihc_core_model
  import ihc_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Controller side
  input wire logic cpu_irq_req,
  input wire logic cpu_clk_en,
  input wire logic [3:0] ack_wait,
  output logic cpu_irq_ack,
  output logic [ihc_pkg::PC_W-1:0] pc_next
);
  import ihc_pkg::*;
  logic [3:0] cnt;
  // Program counter runs while clocked
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pc_next <= 12'h200;
    else if (cpu_clk_en)
      pc_next <= pc_next + 12'h1;
  end
  // Accept after a variable wait, never while halted
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt <= 4'h0;
      cpu_irq_ack <= 1'h0;
    end
    else if (cpu_irq_req && cpu_clk_en && !cpu_irq_ack && cnt >= ack_wait)
    begin
      cnt <= 4'h0;
      cpu_irq_ack <= 1'h1;
    end
    else
    begin
      cnt <= (cpu_irq_req && !cpu_irq_ack) ? cnt + 4'h1 : 4'h0;
      cpu_irq_ack <= 1'h0;
    end
  end
endmodule : ihc_core_model

// ### verif/tb.sv
/*
  Self-checking bench of the interrupt and halt controller.
  Assumes the package, the design and the core model compiled first.
*/
`timescale 1ns/1ps
module tb;
  import ihc_pkg::*;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [9:0] paddr = 10'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready, pslverr, err, cpu_irq_ack, cpu_irq_req, cpu_halted, cpu_clk_en;
  logic stack_wr, pc_load, evt_irq;
  logic [2:0] tick_taps = 3'h0;
  logic [3:0] key_input_lines = 4'h0;
  logic [3:0] ack_wait = 4'h0;
  logic global_irq_on = 1'h0;
  logic global_irq_off = 1'h0;
  logic halt_exec = 1'h0;
  logic [11:0] pc_next, stack_wdata, pc_vector, pn;
  logic [7:0] seed = 8'h57;
  int bad_count = 0;
  int n_compared = 0;
  int cyc = 0;
  int t_acc = 0;
  int q_vec[$];

  ihc_interrupt_halt_controller uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .tick_taps(tick_taps),
    .key_input_lines(key_input_lines), .global_irq_on(global_irq_on),
    .global_irq_off(global_irq_off), .halt_exec(halt_exec), .cpu_irq_ack(cpu_irq_ack),
    .pc_next(pc_next), .cpu_irq_req(cpu_irq_req), .cpu_halted(cpu_halted),
    .cpu_clk_en(cpu_clk_en), .stack_wr(stack_wr), .stack_wdata(stack_wdata),
    .pc_load(pc_load), .pc_vector(pc_vector), .evt_irq(evt_irq));
  ihc_core_model core (.pclk(pclk), .presetn(presetn), .cpu_irq_req(cpu_irq_req),
    .cpu_clk_en(cpu_clk_en), .ack_wait(ack_wait), .cpu_irq_ack(cpu_irq_ack),
    .pc_next(pc_next));

  always #25 pclk = ~pclk;

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr

  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= {idx, 2'h0};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
    apb(1'h0, idx, 32'h0);
    chk(rd, exp);
  endtask : rdc

  task automatic tick_fall(input int i);
    @(posedge pclk);
    tick_taps[i] <= 1'h1;
    repeat (2) @(posedge pclk);
    tick_taps[i] <= 1'h0;
    repeat (3) @(posedge pclk);
  endtask : tick_fall

  task automatic key_rise(input int i);
    @(posedge pclk);
    key_input_lines[i] <= 1'h1;
    repeat (2) @(posedge pclk);
    key_input_lines[i] <= 1'h0;
    repeat (3) @(posedge pclk);
  endtask : key_rise

  task automatic gie_pulse(input logic on);
    @(posedge pclk);
    if (on)
      global_irq_on <= 1'h1;
    else
      global_irq_off <= 1'h1;
    @(posedge pclk);
    global_irq_on <= 1'h0;
    global_irq_off <= 1'h0;
    repeat (3) @(posedge pclk);
  endtask : gie_pulse

  // Timeout and entry sequence monitor
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc > 20000)
    begin
      bad_count++;
      end_sim();
    end
    if (cpu_irq_ack === 1'h1 && cpu_irq_req === 1'h1)
    begin
      t_acc = cyc;
      pn = pc_next;
    end
    if (stack_wr === 1'h1)
    begin
      chk(stack_wdata, pn);
      chk(cyc - t_acc, 1);
    end
    if (pc_load === 1'h1)
    begin
      chk(pc_vector, q_vec.pop_front());
      chk(cyc - t_acc, 12);
    end
  end

  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'h1;
    repeat (2) @(posedge pclk);
    rdc(IDX_KEY_EN, 32'h0);
    rdc(IDX_TICK_EN, 32'h0);
    rdc(IDX_KEY_PEND, 32'h0);
    rdc(IDX_TICK_PEND, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      seed = lfsr(seed);
      apb(1'h1, IDX_KEY_EN, {24'h0, seed});
      rdc(IDX_KEY_EN, {28'h0, seed[3:0]});
      apb(1'h1, IDX_TICK_EN, {24'h0, ~seed});
      rdc(IDX_TICK_EN, {29'h0, ~seed[2:0]});
    end
    apb(1'h1, IDX_KEY_EN, 32'h0);
    apb(1'h1, IDX_TICK_EN, 32'h0);
    for (int i = 0; i < 3; i++)
    begin
      tick_fall(i);
      rdc(IDX_TICK_PEND, 32'h1 << i);
    end
    tick_fall(2);
    apb(1'h1, IDX_TICK_PEND, 32'h0);
    rdc(IDX_TICK_PEND, 32'h4);
    rdc(IDX_TICK_PEND, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      key_rise(i);
      rdc(IDX_KEY_PEND, 32'h1);
    end
    rdc(IDX_KEY_PEND, 32'h0);
    apb(1'h0, 8'h10, 32'h0);
    chk(err, 1'h1);
    chk(rd, 32'h0);
    apb(1'h1, IDX_TICK_EN, 32'h1);
    tick_fall(0);
    chk(cpu_irq_req, 1'h0);
    apb(1'h1, IDX_TICK_EN, 32'h0);
    gie_pulse(1'h1);
    chk(cpu_irq_req, 1'h0);
    gie_pulse(1'h0);
    apb(1'h1, IDX_TICK_EN, 32'h1);
    seed = lfsr(seed);
    ack_wait <= seed[3:0];
    q_vec.push_back({VEC_PAGE, VEC_TICK});
    gie_pulse(1'h1);
    repeat (40) @(posedge pclk);
    rdc(IDX_CTRL, 32'h0);
    chk(cpu_irq_req, 1'h0);
    apb(1'h1, IDX_KEY_EN, 32'h8);
    key_rise(0);
    ack_wait <= 4'h0;
    q_vec.push_back({VEC_PAGE, VEC_KEY});
    apb(1'h1, IDX_CTRL, 32'h1);
    repeat (30) @(posedge pclk);
    rdc(IDX_KEY_PEND, 32'h1);
    rdc(IDX_TICK_PEND, 32'h1);
    @(posedge pclk);
    halt_exec <= 1'h1;
    @(posedge pclk);
    halt_exec <= 1'h0;
    repeat (2) @(posedge pclk);
    chk(cpu_halted, 1'h1);
    chk(cpu_clk_en, 1'h0);
    gie_pulse(1'h1);
    chk(cpu_halted, 1'h1);
    q_vec.push_back({VEC_PAGE, VEC_TICK});
    tick_fall(0);
    chk(cpu_halted, 1'h0);
    chk(cpu_clk_en, 1'h1);
    repeat (30) @(posedge pclk);
    rdc(IDX_TICK_PEND, 32'h1);
    rdc(IDX_EVT_STAT, 32'h3);
    apb(1'h1, IDX_EVT_MASK, 32'h2);
    repeat (2) @(posedge pclk);
    chk(evt_irq, 1'h1);
    apb(1'h1, IDX_EVT_STAT, 32'h2);
    repeat (2) @(posedge pclk);
    chk(evt_irq, 1'h0);
    rdc(IDX_EVT_STAT, 32'h1);
    chk(q_vec.size(), 0);
    end_sim();
  end
endmodule : tb
